// ===== desc_mem_model.sv
// Purpose: descriptor memory and data mover seen by the block
// Assumes: same clock as the block
// Notes: errors move half the length, so partial counts show
`timescale 1ns/1ps
module desc_mem_model
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic [1:0] i_err,
  input wire logic [31:0] i_ctl,
  input wire logic [31:0] i_sts,
  output logic o_desc_valid,
  output logic [31:0] o_ctl,
  output logic [31:0] o_sts,
  input wire logic i_start,
  input wire logic [25:0] i_len,
  output logic o_done = 1'b0,
  output logic [25:0] o_bytes,
  output logic o_tgt,
  output logic o_dec,
  output logic o_idle = 1'b1,
  input wire logic i_wb_valid,
  input wire logic [31:0] i_wb_data,
  input wire logic i_keep,
  output logic o_ready = 1'b0,
  output logic [31:0] o_mem
);
  logic [2:0] cnt = 3'h0;
  logic [1:0] wcnt = 2'h0;
  logic [25:0] len;
  // Fetch, move and store; idle words invert every cycle, so they alternate with the fetched value
  always_ff @(posedge i_clk)
  begin
    o_desc_valid <= i_go;
    o_ctl <= i_go ? i_ctl : ~o_ctl;
    o_sts <= i_go ? i_sts : ~o_sts;
    o_done <= 1'b0;
    if (i_start)
    begin
      cnt <= 3'h3;
      len <= i_len;
    end
    else if (cnt != 3'h0)
    begin
      cnt <= cnt - 3'h1;
      o_done <= cnt == 3'h1;
      o_bytes <= (i_err != 2'h0) ? len >> 1 : len;
      o_tgt <= i_err == 2'h1;
      o_dec <= i_err == 2'h2;
    end
    o_idle <= cnt == 3'h0 && !i_start;
    wcnt <= (i_wb_valid && !o_ready) ? wcnt + 2'h1 : 2'h0;
    o_ready <= i_wb_valid && !o_ready && (!i_slow || wcnt == 2'h2);
    if (i_wb_valid && o_ready)
      o_mem <= i_keep ? {i_wb_data[31:26], o_mem[25:0]} : i_wb_data;
  end
endmodule

// ===== mem_to_stream_channel_descriptor_status_writeback.sv
// Purpose: builds and writes back the memory-to-stream descriptor status word
// Assumes: mover and descriptor memory run on i_clk; APB master on i_clk
// Notes: one descriptor in flight; halts on any error until run/stop is set again
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module mem_to_stream_channel_descriptor_status_writeback
  import wb_pkg::*;
#(
  parameter int BUF_LEN_WIDTH = BUF_LEN_WIDTH_DEF,
  parameter bit LIGHTWEIGHT = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Descriptor fetch result
  input wire logic i_desc_valid,
  input wire logic [31:0] i_desc_control,
  input wire logic [31:0] i_desc_status,
  // Data mover command and result
  output logic o_mover_start,
  output logic [FIELD_WIDTH-1:0] o_mover_len,
  input wire logic i_mover_done,
  input wire logic [FIELD_WIDTH-1:0] i_mover_bytes,
  input wire logic i_mover_tgt_err,
  input wire logic i_mover_dec_err,
  input wire logic i_mover_idle,
  // Status write-back to descriptor memory
  output logic o_wb_valid,
  output logic [31:0] o_wb_data,
  output logic o_wb_keep_count,
  input wire logic i_wb_ready,
  // Engine state
  output logic o_run_stop,
  output logic o_halted,
  output logic o_sg_internal_error,
  output logic o_irq
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Refuse widths the status field cannot carry, before any logic is built
  if (BUF_LEN_WIDTH < 8 || BUF_LEN_WIDTH > FIELD_WIDTH)
  begin : g_bad_width
    $error("BUF_LEN_WIDTH out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_MOVE, ST_WRITE, ST_DRAIN, ST_HALT} state_type;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clip a byte count to the configured usable width
  function automatic logic [FIELD_WIDTH-1:0] clip_len(input logic [FIELD_WIDTH-1:0] len);
    logic [FIELD_WIDTH-1:0] mask;
    mask = '0;
    for (int k = 0; k < BUF_LEN_WIDTH; k++)
    begin
      mask[k] = 1'b1;
    end
    return len & mask;
  endfunction

  state_type state;
  logic [FIELD_WIDTH-1:0] req_len;
  logic [FIELD_WIDTH-1:0] done_bytes;
  logic int_err;
  logic tgt_err;
  logic dec_err;
  logic run_stop;
  logic [EV_COUNT-1:0] irq_status;
  logic [EV_COUNT-1:0] irq_enable;
  logic [EV_COUNT-1:0] next_irq_status;
  logic [EV_COUNT-1:0] events;
  logic [EV_COUNT-1:0] clear_bits;
  logic [31:0] status_word;
  logic [31:0] last_status;
  logic wb_fire;
  logic halt_done;
  logic stale;
  logic zero_len;
  logic apb_access;
  logic apb_wr;
  logic run_set;

  assign apb_access = i_psel && i_penable && o_pready;
  assign apb_wr = apb_access && i_pwrite;
  assign run_set = apb_wr && i_paddr == OFS_CONTROL && i_pwdata[0];
  assign stale = i_desc_valid && state == ST_IDLE && run_stop && i_desc_status[BIT_CMPLT];
  assign zero_len = clip_len(i_desc_control[FIELD_WIDTH-1:0]) == '0;
  assign wb_fire = o_wb_valid && i_wb_ready;
  assign halt_done = state == ST_DRAIN && i_mover_idle;

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  // All fields leave in one word; reserved bits are forced to zero
  always_comb
  begin
    status_word = '0;
    status_word[FIELD_WIDTH-1:0] = clip_len(done_bytes);
    status_word[BIT_RSVD_LO+1:BIT_RSVD_LO] = 2'b00;
    status_word[BIT_INT_ERR] = int_err;
    status_word[BIT_TGT_ERR] = tgt_err;
    status_word[BIT_DEC_ERR] = dec_err;
    status_word[BIT_CMPLT] = 1'b1;
  end

  // ----------------------------------------
  // Descriptor sequencer
  // ----------------------------------------
  // Fetch, move, write back; errors divert to drain then halt
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= ST_IDLE;
      req_len <= '0;
      done_bytes <= '0;
      int_err <= 1'b0;
      tgt_err <= 1'b0;
      dec_err <= 1'b0;
      o_mover_start <= 1'b0;
      o_mover_len <= '0;
      o_wb_valid <= 1'b0;
      o_wb_data <= '0;
      o_wb_keep_count <= 1'b0;
      o_sg_internal_error <= 1'b0;
      o_halted <= 1'b0;
    end
    else
    begin
      o_mover_start <= 1'b0;
      if (run_set)
      begin
        o_halted <= 1'b0;
        o_sg_internal_error <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          if (i_desc_valid && run_stop)
          begin
            if (stale)
            begin
              o_sg_internal_error <= 1'b1;
              state <= ST_DRAIN;
            end
            else
            begin
              req_len <= clip_len(i_desc_control[FIELD_WIDTH-1:0]);
              o_mover_len <= clip_len(i_desc_control[FIELD_WIDTH-1:0]);
              o_mover_start <= 1'b1;
              int_err <= zero_len;
              tgt_err <= 1'b0;
              dec_err <= 1'b0;
              done_bytes <= '0;
              state <= ST_MOVE;
            end
          end
        end
        ST_MOVE:
        begin
          if (i_mover_done)
          begin
            tgt_err <= i_mover_tgt_err;
            dec_err <= i_mover_dec_err;
            // Normal completion reports the requested length
            if (!int_err && !i_mover_tgt_err && !i_mover_dec_err)
            begin
              done_bytes <= req_len;
            end
            else
            begin
              done_bytes <= i_mover_bytes;
            end
            state <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (!o_wb_valid)
          begin
            o_wb_valid <= 1'b1;
            o_wb_data <= status_word;
            o_wb_keep_count <= LIGHTWEIGHT;
          end
          else if (i_wb_ready)
          begin
            o_wb_valid <= 1'b0;
            state <= (int_err || tgt_err || dec_err) ? ST_DRAIN : ST_IDLE;
          end
        end
        ST_DRAIN:
        begin
          // Halted only once the mover has fully stopped
          if (i_mover_idle)
          begin
            o_halted <= 1'b1;
            state <= ST_HALT;
          end
        end
        ST_HALT:
        begin
          if (run_set)
          begin
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Run/stop control bit
  // ----------------------------------------
  // Hardware clear on error wins over a software write in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      run_stop <= RUN_STOP_RESET;
    end
    else if (stale || (state == ST_MOVE && i_mover_done && (int_err || i_mover_tgt_err || i_mover_dec_err)))
    begin
      run_stop <= 1'b0;
    end
    else if (apb_wr && i_paddr == OFS_CONTROL)
    begin
      run_stop <= i_pwdata[0];
    end
  end

  // ----------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------
  always_comb
  begin
    events = '0;
    events[EV_DONE] = wb_fire;
    events[EV_ERROR] = wb_fire && (int_err || tgt_err || dec_err);
    events[EV_STALE] = stale;
    events[EV_HALTED] = halt_done;
    clear_bits = (apb_wr && i_paddr == OFS_IRQ_CLEAR) ? i_pwdata[EV_COUNT-1:0] : '0;
    // Set beats clear so no event is lost
    next_irq_status = (irq_status & ~clear_bits) | events;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      irq_status <= '0;
      irq_enable <= IRQ_ENABLE_RESET;
      o_irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (apb_wr && i_paddr == OFS_IRQ_ENABLE)
      begin
        irq_enable <= i_pwdata[EV_COUNT-1:0];
      end
      o_irq <= |(next_irq_status & irq_enable);
    end
  end

  // Keep a copy of the last word written back for software
  wb_status_reg #(
    .WIDTH(32)
  ) u_last (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_we(wb_fire),
    .i_wdata(o_wb_data),
    .o_rdata(last_status)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: pready rises in the second access cycle, read data registered
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      if (i_psel && i_penable && !o_pready)
      begin
        case (i_paddr)
          OFS_CONTROL: o_prdata <= {31'h0, run_stop};
          OFS_STATE: o_prdata <= {29'h0, o_sg_internal_error, o_halted, run_stop};
          OFS_IRQ_STATUS: o_prdata <= {28'h0, irq_status};
          OFS_IRQ_ENABLE: o_prdata <= {28'h0, irq_enable};
          OFS_IRQ_CLEAR: o_prdata <= '0;
          OFS_LAST_STATUS: o_prdata <= last_status;
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  assign o_run_stop = run_stop;
endmodule

// ===== mem_to_stream_channel_descriptor_status_writeback_bench.sv
// Purpose: self-checking bench of the status write-back block
// Assumes: APB master tasks, descriptor model beside the block
// Notes: error cases mask the completed bit, whose value there is open
`timescale 1ns/1ps
module mem_to_stream_channel_descriptor_status_writeback_bench;
  import wb_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, ctl = 32'h0, sts = 32'h0, dctl, dsts, wdata, mem, r;
  logic [1:0] err = 2'h0;
  logic pready, pslverr, dvalid, start, done, tgt, dec, idle, wvalid, keep, wready, run, halted, sgerr, irq;
  logic [25:0] mlen, bytes;
  int miscompares = 0, checks = 0;
  logic [31:0] ectl [3] = '{32'h40, 32'h40, 32'h0};
  logic [31:0] eexp [3] = '{32'h20000020, 32'h40000020, 32'h10000000};
  initial forever #2.5 clk = ~clk;
  mem_to_stream_channel_descriptor_status_writeback i_mem_to_stream_channel_descriptor_status_writeback (.i_clk(clk), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_desc_valid(dvalid),
    .i_desc_control(dctl), .i_desc_status(dsts), .o_mover_start(start), .o_mover_len(mlen),
    .i_mover_done(done), .i_mover_bytes(bytes), .i_mover_tgt_err(tgt), .i_mover_dec_err(dec),
    .i_mover_idle(idle), .o_wb_valid(wvalid), .o_wb_data(wdata), .o_wb_keep_count(keep),
    .i_wb_ready(wready), .o_run_stop(run), .o_halted(halted), .o_sg_internal_error(sgerr), .o_irq(irq));
  desc_mem_model i_desc_mem_model (.i_clk(clk), .i_go(go), .i_slow(slow), .i_err(err), .i_ctl(ctl),
    .i_sts(sts), .o_desc_valid(dvalid), .o_ctl(dctl), .o_sts(dsts), .i_start(start), .i_len(mlen),
    .o_done(done), .o_bytes(bytes), .o_tgt(tgt), .o_dec(dec), .o_idle(idle), .i_wb_valid(wvalid),
    .i_wb_data(wdata), .i_keep(keep), .o_ready(wready), .o_mem(mem));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bounded wait: 0 for a write-back handshake, 1 for halted
  task automatic wt(input int sel);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (((sel == 0) ? (wvalid && wready) : halted) !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Request held until pready is sampled high, released after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      wrap_up();
    end
    q = w ? {31'h0, pslverr} : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_desc(input logic [31:0] c, input logic [31:0] s, input logic [1:0] e,
    input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clk);
    // Each descriptor is a whole packet: first and last buffer marks both set
    ctl <= c | 32'h0c000000;
    sts <= s;
    err <= e;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wt(0);
    chk("wb_data", wdata & mask, exp);
    @(posedge clk);
    chk("memory", mem & mask, exp);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b1, OFS_CONTROL, 32'h1, r);
    apb(1'b1, OFS_IRQ_ENABLE, 32'hf, r);
    apb(0, OFS_STATE, 0, r);
    chk("state", r & 32'h7, 32'h1);
    run_desc(32'h123, 32'h0c000000, 2'h0, 32'h80000123, 32'hffffffff);
    apb(0, OFS_LAST_STATUS, 0, r);
    chk("last", r, 32'h80000123);
    apb(0, OFS_IRQ_STATUS, 0, r);
    chk("irq_sts", r & 32'hf, 32'h1);
    chk("irq", irq, 1);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hf, r);
    apb(0, OFS_IRQ_STATUS, 0, r);
    chk("irq_clr", r & 32'hf, 32'h0);
    chk("irq_low", irq, 0);
    slow <= 1'b1;
    run_desc(32'h3ffffff, 32'h0, 2'h0, 32'h83ffffff, 32'hffffffff);
    for (int i = 0; i < 3; i++)
    begin
      run_desc(ectl[i], 32'h0, 2'(i + 1 == 3 ? 0 : i + 1), eexp[i], 32'h7fffffff);
      wt(1);
      chk("run_stop", run, 0);
      apb(0, OFS_STATE, 0, r);
      chk("halted", r & 32'h7, 32'h2);
      apb(1'b1, OFS_CONTROL, 32'h1, r);
    end
    @(posedge clk);
    sts <= 32'h80000000;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    chk("stale_err", sgerr, 1);
    chk("stale_run", run, 0);
    chk("stale_wb", wvalid, 0);
    apb(0, OFS_IRQ_STATUS, 0, r);
    chk("irq_all", r & 32'hf, 32'hf);
    apb(1'b1, OFS_CONTROL, 32'h1, r);
    apb(0, OFS_STATE, 0, r);
    chk("resumed", r & 32'h7, 32'h1);
    apb(1'b1, 8'h20, 32'h1, r);
    chk("unmapped", r, 32'h1);
    wrap_up();
  end
endmodule

// ===== wb_chk.sv
// Purpose: port-level checks of the status write-back block
// Assumes: single clock, active-low async reset
// Notes: bound to the top module; sees its ports only
`timescale 1ns/1ps
module wb_chk
  import wb_pkg::*;
#(
  parameter int BUF_LEN_WIDTH = BUF_LEN_WIDTH_DEF,
  parameter bit LIGHTWEIGHT = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_desc_valid,
  input wire logic [31:0] i_desc_control,
  input wire logic [31:0] i_desc_status,
  input wire logic o_mover_start,
  input wire logic [FIELD_WIDTH-1:0] o_mover_len,
  input wire logic i_mover_done,
  input wire logic i_mover_tgt_err,
  input wire logic i_mover_dec_err,
  input wire logic i_mover_idle,
  input wire logic o_wb_valid,
  input wire logic [31:0] o_wb_data,
  input wire logic o_wb_keep_count,
  input wire logic i_wb_ready,
  input wire logic o_run_stop,
  input wire logic o_halted,
  input wire logic o_sg_internal_error
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Wraps to all ones at full width, so one form serves every width
  localparam logic [25:0] LEN_MASK = (26'h1 << BUF_LEN_WIDTH) - 26'h1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  start_has_desc_a: assert property (o_mover_start |-> $past(i_desc_valid))
    else $error("mover start without a descriptor");
  len_masked_a: assert property (o_mover_start |-> o_mover_len == ($past(i_desc_control[25:0]) & LEN_MASK))
    else $error("mover length differs from control word");
  stale_cause_a: assert property ($rose(o_sg_internal_error) |-> $past(i_desc_valid && i_desc_status[31]))
    else $error("internal error without stale descriptor");
  stale_stop_a: assert property ($rose(o_sg_internal_error) |-> !o_run_stop)
    else $error("run stays set after stale descriptor");
  rsvd_zero_a: assert property (o_wb_valid |-> o_wb_data[27:26] == 2'h0)
    else $error("reserved status bits written nonzero");
  wb_hold_a: assert property (o_wb_valid && !i_wb_ready |=> o_wb_valid && $stable(o_wb_data))
    else $error("write-back dropped or changed before ready");
  wb_latency_a: assert property (i_mover_done |-> ##2 o_wb_valid)
    else $error("no write-back two cycles after done");
  err_stop_a: assert property (i_mover_done && (i_mover_tgt_err || i_mover_dec_err) |=> !o_run_stop)
    else $error("run not cleared on mover error");
  halt_idle_a: assert property ($rose(o_halted) |-> $past(i_mover_idle))
    else $error("halted set while mover busy");
  tgt_bit_a: assert property (i_mover_done && i_mover_tgt_err |-> ##2 o_wb_data[29])
    else $error("target error bit missing");
  dec_bit_a: assert property (i_mover_done && i_mover_dec_err |-> ##2 o_wb_data[30])
    else $error("decode error bit missing");
  keep_cnt_a: assert property (o_wb_valid |-> o_wb_keep_count == LIGHTWEIGHT)
    else $error("keep-count flag does not match build");
  cover property (o_wb_valid && i_wb_ready);
  cover property ($rose(o_halted));
  cover property ($rose(o_sg_internal_error));
endmodule
bind mem_to_stream_channel_descriptor_status_writeback wb_chk #(.BUF_LEN_WIDTH(BUF_LEN_WIDTH), .LIGHTWEIGHT(LIGHTWEIGHT)) i_wb_chk (.*);

// ===== wb_pkg.sv
// Purpose: constants for the descriptor status write-back block
// Assumes: one clock, active-low asynchronous reset, APB register access
// Notes: offsets of the APB registers are local choices
//
// Notes on behaviour
// - After a descriptor, write the bytes actually moved into status bits 25..0.
// - Byte count width follows a buffer-length-width parameter, up to 26 bits.
// - Lightweight build leaves the byte count field of the status word untouched.
// - A normally completed descriptor reports exactly its requested buffer length.
// - Status bits 27 and 26 are reserved; software zeroes them, device writes zero.
// - Zero buffer length in a fetched descriptor sets the internal error bit 28.
// - Any data error clears run/stop, then sets halted once the engine is idle.
// - Target error response on a mover read sets bit 29.
// - Decode error on the buffer address sets bit 30.
// - Completed bit 31 is set once the descriptor's transfer has finished.
// - A descriptor fetched already completed is stale: flag internal error, halt.
package wb_pkg;
  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int FIELD_WIDTH = 26;
  localparam int BIT_RSVD_LO = 26;
  localparam int BIT_INT_ERR = 28;
  localparam int BIT_TGT_ERR = 29;
  localparam int BIT_DEC_ERR = 30;
  localparam int BIT_CMPLT = 31;
  localparam int BUF_LEN_WIDTH_DEF = 26;
  // ----------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_LAST_STATUS = 8'h14;
  // ----------------------------------------
  // Interrupt event bits
  // ----------------------------------------
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_STALE = 2;
  localparam int EV_HALTED = 3;
  localparam int EV_COUNT = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RUN_STOP_RESET = 1'b0;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
endpackage

// ===== wb_status_reg.sv
// Purpose: holds the last written-back status word, read data out of a register
// Assumes: same clock and reset as the main block
// Notes: one word, written on each write-back
`timescale 1ns/1ps
module wb_status_reg
  import wb_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_we,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_rdata
);
  // Capture the word on each write strobe
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= '0;
    end
    else if (i_we)
    begin
      o_rdata <= i_wdata;
    end
  end
endmodule
